// ===== shared/tlivu_defs.vh
`ifndef TLIVU_DEFS_VH
`define TLIVU_DEFS_VH

// register byte offsets on the wishbone slave
`define TLIVU_OFF_RECV_LO    8'h00
`define TLIVU_OFF_RECV_HI    8'h04
`define TLIVU_OFF_VECTOR     8'h08
`define TLIVU_OFF_SOFTIRQ    8'h0c
`define TLIVU_OFF_STATE      8'h10
`define TLIVU_OFF_TRAP       8'h14

// trap depth limits
`define TLIVU_MAX_TRAP_DEPTH  3'd6
`define TLIVU_MAX_PRIV_DEPTH  3'd2
`define TLIVU_DEPTH_RST       3'd0

// state register fields
`define TLIVU_ST_DEPTH_LSB   0
`define TLIVU_ST_HYPER_BIT   4
`define TLIVU_ST_PRIV_BIT    5
`define TLIVU_ST_USER_BIT    6
`define TLIVU_ST_BPEN_BIT    8
`define TLIVU_ST_RECOV_BIT   9
`define TLIVU_BPEN_RST       1'b0

// trap types
`define TLIVU_TT_ILLEGAL     9'h010
`define TLIVU_TT_BREAKPOINT  9'h076
`define TLIVU_TT_ACCESS_ERR  9'h032
`define TLIVU_TT_SOFT_BASE   9'h040
`define TLIVU_TT_VECTOR      9'h060
`define TLIVU_TT_MODULAR     9'h074
`define TLIVU_TT_DATA_ERR    9'h078
`define TLIVU_TT_STRAND_MON  9'h07c
`define TLIVU_TT_DEVICE_MON  9'h07d
`define TLIVU_TT_RECOV_FLT   9'h07e
`define TLIVU_TT_HTRAP_BASE  9'h180
`define TLIVU_TT_WDOG_ENTRY  9'h002

// priorities in tenths, lower is more urgent
`define TLIVU_PRI_BREAKPOINT 10'd70
`define TLIVU_PRI_ILLEGAL    10'd71
`define TLIVU_PRI_DATA_ERR   10'd130
`define TLIVU_PRI_MONDO      10'd160
`define TLIVU_PRI_MODULAR    10'd160
`define TLIVU_PRI_VECTOR     10'd263
`define TLIVU_PRI_RECOV_FLT  10'd330
`define TLIVU_PRI_ACCESS_ERR 10'd120
`define TLIVU_PRI_SOFT       10'd300

`endif

// ===== hdl/tlivu_recv_reg.v
`default_nettype none
`include "tlivu_defs.vh"

module tlivu_recv_reg #(
    parameter VEC_W = 6,
    parameter NVEC = 64
) (
    input wire clk_i, // core clock
    input wire rst_i, // sync reset
    input wire set_en_i, // incoming vector valid
    input wire [VEC_W-1:0] set_vec_i, // incoming vector id
    input wire [NVEC-1:0] clr_mask_i, // ones clear bits
    output reg [NVEC-1:0] pend_o, // pending bits
    output reg [VEC_W-1:0] top_o, // highest pending vector
    output reg any_o // any bit pending
);
    reg [VEC_W-1:0] top_d;
    wire [NVEC-1:0] pend_d;
    integer k;

    genvar g;
    generate
        for (g = 0; g < NVEC; g = g + 1)
        begin : g_bit
            localparam [VEC_W-1:0] IDX = g;
            // set wins over a clear in the same cycle; a repeated set is simply absorbed
            assign pend_d[g] = (set_en_i && set_vec_i == IDX) || (pend_o[g] && !clr_mask_i[g]); // [RULE12] [RULE13] [RULE18]
        end
    endgenerate

    // scan upward so the highest set bit is last to win
    always @*
    begin
        top_d = {VEC_W{1'b0}};
        for (k = 0; k < NVEC; k = k + 1)
            if (pend_o[k])
                top_d = k[VEC_W-1:0]; // [RULE14]
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_o <= {NVEC{1'b0}};
            top_o <= {VEC_W{1'b0}};
            any_o <= 1'b0;
        end
        else
        begin
            pend_o <= pend_d;
            top_o <= top_d;
            any_o <= |pend_o;
        end
    end
endmodule // tlivu_recv_reg
`default_nettype wire

// ===== hdl/tlivu_top.v
`default_nettype none
`include "tlivu_defs.vh"

// Operation
// RULE1 - six trap levels supported per strand
// RULE2 - overflow at privileged limit goes hyperprivileged watchdog
// RULE3 - hypervisor trap forces software number bit7
// RULE4 - user hypervisor trap raises illegal instruction
// RULE5 - strand mondo, device mondo, recoverable fault traps
// RULE6 - modular, vectored, deferred error implementation traps
// RULE7 - breakpoint priority seven clears enable bit
// RULE8 - only breakpoint trap clears enable bit
// RULE9 - precise versus deferred memory error split
// RULE10 - soft interrupts use types 41 to 4f
// RULE11 - io and strand interrupts use type 60
// RULE12 - six bit vector selects receive bit
// RULE13 - sixty four pending bits one per vector
// RULE14 - vector 63 highest, vector 0 lowest
// RULE15 - bridge table picks strand and vector
// RULE16 - write clears bits with zero data
// RULE17 - vector read returns top and clears it
// RULE18 - set beats same cycle clear
// RULE19 - vector trap requested while any bit pending
module tlivu_top #(
    parameter VEC_W = 6,
    parameter NVEC = 64
) (
    input wire clk_i, // core clock 100 MHz
    input wire rst_i, // sync reset, active high
    input wire [7:0] wb_adr_i, // wishbone byte address
    input wire [31:0] wb_dat_i, // wishbone write data
    input wire [3:0] wb_sel_i, // wishbone byte lanes
    input wire wb_we_i, // wishbone write
    input wire wb_cyc_i, // wishbone cycle
    input wire wb_stb_i, // wishbone strobe
    output reg [31:0] wb_dat_o, // wishbone read data
    output reg wb_ack_o, // wishbone ack
    output reg wb_err_o, // unmapped access
    input wire irq_valid_i, // incoming io or strand interrupt
    input wire [VEC_W-1:0] irq_vec_i, // its vector from the routing table
    input wire [6:0] swtrap_num_i, // software trap number
    input wire htrap_i, // hypervisor trap instruction
    input wire bkpt_i, // instruction breakpoint
    input wire illegal_i, // undefined opcode
    input wire mem_err_precise_i, // precise catastrophic memory error
    input wire mem_err_defer_i, // disrupting catastrophic memory error
    input wire strand_mondo_i, // strand mondo
    input wire device_mondo_i, // device mondo
    input wire recov_fault_i, // recoverable fault
    input wire modular_done_i, // modular arithmetic done
    input wire trap_ret_i, // trap return, depth minus one
    output reg trap_o, // trap taken pulse
    output reg [8:0] trap_type_o, // recorded trap type
    output reg [8:0] trap_entry_o, // vector table entry
    output reg [9:0] trap_pri_o, // priority in tenths
    output reg vec_irq_o, // vectored interrupt request level
    output reg [2:0] trap_depth_o, // current trap depth
    output reg breakpoint_enable_bit_o, // breakpoint enable
    output reg recovery_state_o // recovery state flag
);
    reg [2:0] trap_depth_q;
    reg hyper_q, priv_q;
    reg bpen_q, recov_q;
    reg [15:0] soft_irq_register_q;
    reg [NVEC-1:0] clr_mask;
    wire [NVEC-1:0] pend;
    wire [VEC_W-1:0] top_vec;
    wire any_pend;
    // a held strobe is taken every other cycle; the next request needs ack or err to drop first
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    reg sel_ok;
    reg [31:0] rdata;
    reg [8:0] tt_d, entry_d;
    reg [9:0] pri_d;
    reg take_d, to_hyper_d;
    reg [3:0] soft_lvl;
    integer i;

    // clears are gated by the request so a strobe lingering into the ack cycle clears only once
    always @*
    begin
        sel_ok = 1'b1;
        clr_mask = {NVEC{1'b0}};
        rdata = 32'h0000_0000;
        if (wb_adr_i == `TLIVU_OFF_RECV_LO)
        begin
            rdata = pend[31:0];
            if (wb_req && wb_we_i)
                clr_mask[31:0] = ~wb_dat_i; // [RULE16]
        end
        else if (wb_adr_i == `TLIVU_OFF_RECV_HI)
        begin
            rdata = pend[63:32];
            if (wb_req && wb_we_i)
                clr_mask[63:32] = ~wb_dat_i; // [RULE16]
        end
        else if (wb_adr_i == `TLIVU_OFF_VECTOR)
        begin
            // registered top vector, so the value returned and the bit cleared agree
            rdata = {26'h000_0000, top_vec}; // [RULE17]
            if (wb_req && !wb_we_i && any_pend)
                clr_mask[top_vec] = 1'b1; // [RULE17]
        end
        else if (wb_adr_i == `TLIVU_OFF_SOFTIRQ)
            rdata = {16'h0000, soft_irq_register_q};
        else if (wb_adr_i == `TLIVU_OFF_STATE)
        begin
            rdata[`TLIVU_ST_DEPTH_LSB +: 3] = trap_depth_q;
            rdata[`TLIVU_ST_HYPER_BIT] = hyper_q;
            rdata[`TLIVU_ST_PRIV_BIT] = priv_q;
            rdata[`TLIVU_ST_USER_BIT] = !hyper_q && !priv_q;
            rdata[`TLIVU_ST_BPEN_BIT] = bpen_q;
            rdata[`TLIVU_ST_RECOV_BIT] = recov_q;
        end
        else if (wb_adr_i == `TLIVU_OFF_TRAP)
            // last trap taken: priority above, type below
            rdata = {13'h0000, trap_pri_o, trap_type_o};
        else
            sel_ok = 1'b0;
    end

    tlivu_recv_reg #(
        .VEC_W(VEC_W),
        .NVEC(NVEC)
    ) u_recv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_en_i(irq_valid_i), // [RULE11] [RULE15]
        .set_vec_i(irq_vec_i),
        .clr_mask_i(clr_mask),
        .pend_o(pend),
        .top_o(top_vec),
        .any_o(any_pend)
    );

    // highest pending soft level, 15 wins
    always @*
    begin
        soft_lvl = 4'h0;
        for (i = 1; i < 16; i = i + 1)
            if (soft_irq_register_q[i])
                soft_lvl = i[3:0];
    end

    // trap arbiter: most urgent source first
    always @*
    begin
        take_d = 1'b1;
        to_hyper_d = 1'b0;
        tt_d = 9'h000;
        pri_d = 10'd0;
        // breakpoint outranks everything, the undefined opcode included
        if (bkpt_i)
        begin
            tt_d = `TLIVU_TT_BREAKPOINT; // [RULE7]
            pri_d = `TLIVU_PRI_BREAKPOINT;
            to_hyper_d = 1'b1;
        end
        // user code may not reach the hypervisor through its trap instruction
        else if (illegal_i || (htrap_i && !hyper_q && !priv_q))
        begin
            tt_d = `TLIVU_TT_ILLEGAL; // [RULE4]
            pri_d = `TLIVU_PRI_ILLEGAL;
        end
        else if (htrap_i)
        begin
            tt_d = `TLIVU_TT_HTRAP_BASE | {2'b00, swtrap_num_i}; // [RULE3]
            pri_d = `TLIVU_PRI_ILLEGAL + 10'd1;
            to_hyper_d = 1'b1;
        end
        else if (mem_err_precise_i)
        begin
            tt_d = `TLIVU_TT_ACCESS_ERR; // [RULE9]
            pri_d = `TLIVU_PRI_ACCESS_ERR;
        end
        else if (mem_err_defer_i)
        begin
            tt_d = `TLIVU_TT_DATA_ERR; // [RULE9] [RULE6]
            pri_d = `TLIVU_PRI_DATA_ERR;
        end
        else if (strand_mondo_i)
        begin
            tt_d = `TLIVU_TT_STRAND_MON; // [RULE5]
            pri_d = `TLIVU_PRI_MONDO;
            to_hyper_d = 1'b1;
        end
        else if (device_mondo_i)
        begin
            tt_d = `TLIVU_TT_DEVICE_MON; // [RULE5]
            pri_d = `TLIVU_PRI_MONDO;
            to_hyper_d = 1'b1;
        end
        else if (modular_done_i)
        begin
            tt_d = `TLIVU_TT_MODULAR; // [RULE6]
            pri_d = `TLIVU_PRI_MODULAR;
        end
        else if (any_pend)
        begin
            tt_d = `TLIVU_TT_VECTOR; // [RULE6] [RULE11]
            pri_d = `TLIVU_PRI_VECTOR;
        end
        else if (soft_lvl != 4'h0)
        begin
            tt_d = `TLIVU_TT_SOFT_BASE | {5'h00, soft_lvl}; // [RULE10]
            pri_d = `TLIVU_PRI_SOFT;
        end
        else if (recov_fault_i)
        begin
            tt_d = `TLIVU_TT_RECOV_FLT; // [RULE5]
            pri_d = `TLIVU_PRI_RECOV_FLT;
            to_hyper_d = 1'b1;
        end
        else
            take_d = 1'b0;
        // a trap cannot nest past the limit
        if (trap_depth_q == `TLIVU_MAX_TRAP_DEPTH) // [RULE1]
            take_d = 1'b0;
        // overflow keeps the cause's type but enters through the watchdog entry
        entry_d = tt_d;
        if (!to_hyper_d && priv_q && trap_depth_q == `TLIVU_MAX_PRIV_DEPTH)
        begin
            to_hyper_d = 1'b1;
            entry_d = `TLIVU_TT_WDOG_ENTRY; // [RULE2]
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trap_depth_q <= `TLIVU_DEPTH_RST;
            hyper_q <= 1'b1;
            priv_q <= 1'b0;
            bpen_q <= `TLIVU_BPEN_RST;
            recov_q <= 1'b0;
            soft_irq_register_q <= 16'h0000;
            trap_o <= 1'b0;
            trap_type_o <= 9'h000;
            trap_entry_o <= 9'h000;
            trap_pri_o <= 10'd0;
        end
        else
        begin
            trap_o <= take_d;
            if (take_d)
            begin
                trap_depth_q <= trap_depth_q + 3'd1; // [RULE2]
                trap_type_o <= tt_d; // [RULE2]
                trap_entry_o <= entry_d;
                trap_pri_o <= pri_d;
                hyper_q <= to_hyper_d || hyper_q;
                priv_q <= !(to_hyper_d || hyper_q);
                // no trap enters recovery, not even the watchdog overflow
                recov_q <= 1'b0; // [RULE2]
                if (bkpt_i)
                    bpen_q <= 1'b0; // [RULE7] [RULE8]
            end
            // a return in a trap cycle is dropped; the trap's increment wins
            else if (trap_ret_i && trap_depth_q != 3'd0)
                trap_depth_q <= trap_depth_q - 3'd1;
            // half-word writes only, so a byte write cannot leave a torn level mask
            if (wb_req && wb_we_i && wb_adr_i == `TLIVU_OFF_SOFTIRQ && wb_sel_i[0] && wb_sel_i[1])
                soft_irq_register_q <= wb_dat_i[15:0]; // [RULE10]
            // a software state write loses to a trap taken in the same cycle
            if (wb_req && wb_we_i && wb_adr_i == `TLIVU_OFF_STATE && wb_sel_i[1] && !take_d)
            begin
                bpen_q <= wb_dat_i[`TLIVU_ST_BPEN_BIT];
                recov_q <= wb_dat_i[`TLIVU_ST_RECOV_BIT];
            end
            if (wb_req && wb_we_i && wb_adr_i == `TLIVU_OFF_STATE && wb_sel_i[0] && !take_d)
            begin
                hyper_q <= wb_dat_i[`TLIVU_ST_HYPER_BIT];
                priv_q <= wb_dat_i[`TLIVU_ST_PRIV_BIT];
            end
        end
    end

    // state copies lag by one cycle so every pin comes from a flop
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            vec_irq_o <= 1'b0;
            trap_depth_o <= `TLIVU_DEPTH_RST;
            breakpoint_enable_bit_o <= `TLIVU_BPEN_RST;
            recovery_state_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req && sel_ok;
            wb_err_o <= wb_req && !sel_ok;
            wb_dat_o <= (wb_req && !wb_we_i) ? rdata : 32'h0000_0000;
            // taken from the raw pending bits so the request follows irq_valid_i by two cycles
            vec_irq_o <= |pend; // [RULE19]
            trap_depth_o <= trap_depth_q;
            breakpoint_enable_bit_o <= bpen_q;
            recovery_state_o <= recov_q;
        end
    end
endmodule // tlivu_top
`default_nettype wire

// ===== tb/tlivu_src_model.sv
`default_nettype none
// stands in for the bridge table and the other strands
module tlivu_src_model (
    input wire logic clk_i, // core clock
    input wire logic go_i, // send one interrupt
    input wire logic [5:0] vec_i, // vector picked by the table
    output logic valid_o, // interrupt strobe
    output logic [5:0] vec_o // vector to the strand
);
    timeunit 1ns;
    timeprecision 1ps;
    initial valid_o = 1'b0;
    initial vec_o = 6'h00;
    always @(posedge clk_i)
    begin
        valid_o <= go_i;
        // idle lines toggle so a stale vector is never mistaken for a fresh one
        vec_o <= go_i ? vec_i : ~vec_o;
    end
endmodule // tlivu_src_model
`default_nettype wire

// ===== tb/tlivu_monitor.sv
`default_nettype none
`include "tlivu_defs.vh"
module tlivu_monitor (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic [6:0] swtrap_num_i, // trap number
    input wire logic bkpt_i, // breakpoint cause
    input wire logic irq_valid_i, // vector strobe
    input wire logic trap_o, // trap pulse
    input wire logic [8:0] trap_type_o, // trap type
    input wire logic [8:0] trap_entry_o, // table entry
    input wire logic [9:0] trap_pri_o, // priority
    input wire logic vec_irq_o, // vector request
    input wire logic [2:0] trap_depth_o, // depth
    input wire logic breakpoint_enable_bit_o // enable bit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire bk = trap_o && trap_type_o == `TLIVU_TT_BREAKPOINT;
    property p_vec_set;
        irq_valid_i |-> ##2 vec_irq_o;
    endproperty
    a_vec_set: assert property (p_vec_set) else $error("no vector request");
    property p_vec_rise;
        $rose(vec_irq_o) |-> $past(irq_valid_i, 2);
    endproperty
    a_vec_rise: assert property (p_vec_rise) else $error("request without vector");
    property p_depth;
        trap_depth_o <= `TLIVU_MAX_TRAP_DEPTH;
    endproperty
    a_depth: assert property (p_depth) else $error("depth above limit");
    property p_bk_take;
        bkpt_i && trap_depth_o < 3'd5 |=> bk && trap_pri_o == `TLIVU_PRI_BREAKPOINT;
    endproperty
    a_bk_take: assert property (p_bk_take) else $error("breakpoint not taken");
    property p_bk_clr;
        bk |-> ##[1:2] !breakpoint_enable_bit_o;
    endproperty
    a_bk_clr: assert property (p_bk_clr) else $error("enable not cleared");
    property p_bk_keep;
        $fell(breakpoint_enable_bit_o) |-> $past(bk) || $past(bk, 2);
    endproperty
    a_bk_keep: assert property (p_bk_keep) else $error("enable cleared by other trap");
    property p_htrap;
        trap_o && trap_type_o[8] |-> trap_type_o == {2'b11, $past(swtrap_num_i)};
    endproperty
    a_htrap: assert property (p_htrap) else $error("hyper trap number wrong");
    property p_mondo;
        trap_o && trap_type_o[8:1] == 8'h3e |-> trap_pri_o == `TLIVU_PRI_MONDO;
    endproperty
    a_mondo: assert property (p_mondo) else $error("mondo priority wrong");
    property p_derr;
        trap_o && trap_type_o == `TLIVU_TT_DATA_ERR |-> trap_pri_o == `TLIVU_PRI_DATA_ERR;
    endproperty
    a_derr: assert property (p_derr) else $error("deferred error priority wrong");
    c_wdog: cover property (trap_o && trap_entry_o == `TLIVU_TT_WDOG_ENTRY);
    c_vec: cover property ($rose(vec_irq_o));
    c_bk: cover property (bk);
endmodule // tlivu_monitor
bind tlivu_top tlivu_monitor i_tlivu_monitor (.*);
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
`include "tlivu_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic we = 1'b0, stb = 1'b0, go = 1'b0, tr = 1'b0, e;
    logic [5:0] gv = 6'h00;
    logic [8:0] cz = 9'h000;
    logic [6:0] sw = 7'h05;
    logic [31:0] q;
    wire logic [31:0] rd;
    wire logic ack, err, iv, trap_o, vq, bpe, rec;
    wire logic [5:0] ivec;
    wire logic [8:0] tt, te;
    wire logic [9:0] tp;
    wire logic [2:0] dep;
    int errors = 0;
    int checks_done = 0;
    logic [8:0] xt[8] = '{`TLIVU_TT_BREAKPOINT, `TLIVU_TT_ILLEGAL, `TLIVU_TT_ACCESS_ERR, `TLIVU_TT_DATA_ERR,
        `TLIVU_TT_STRAND_MON, `TLIVU_TT_DEVICE_MON, `TLIVU_TT_RECOV_FLT, `TLIVU_TT_MODULAR};
    logic [9:0] xp[8] = '{10'd70, 10'd71, 10'd120, 10'd130, 10'd160, 10'd160, 10'd330, 10'd160};
    tlivu_top i_tlivu_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
        .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err),
        .irq_valid_i(iv), .irq_vec_i(ivec), .swtrap_num_i(sw), .htrap_i(cz[8]), .bkpt_i(cz[0]),
        .illegal_i(cz[1]), .mem_err_precise_i(cz[2]), .mem_err_defer_i(cz[3]), .strand_mondo_i(cz[4]),
        .device_mondo_i(cz[5]), .recov_fault_i(cz[6]), .modular_done_i(cz[7]), .trap_ret_i(tr),
        .trap_o(trap_o), .trap_type_o(tt), .trap_entry_o(te), .trap_pri_o(tp), .vec_irq_o(vq),
        .trap_depth_o(dep), .breakpoint_enable_bit_o(bpe), .recovery_state_o(rec));
    tlivu_src_model i_tlivu_src_model (.clk_i(clk_i), .go_i(go), .vec_i(gv), .valid_o(iv), .vec_o(ivec));
    initial forever #5 clk_i = ~clk_i;
    task automatic wrap_up();
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic lim(input int n);
        if (n < 20)
            return;
        errors++;
        wrap_up();
    endtask
    // classic single cycle; ack is read at the edge that samples it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (n = 0; n < 20 && !(ack || err); n++)
            @(posedge clk_i);
        lim(n);
        q = rd;
        e = err;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic fire(input int i, input logic [8:0] t, input logic [9:0] p);
        int n;
        cz[i] <= 1'b1;
        @(posedge clk_i);
        cz[i] <= 1'b0;
        for (n = 0; n < 20 && trap_o !== 1'b1; n++)
            @(posedge clk_i);
        lim(n);
        chk(32'(tt), 32'(t));
        if (i < 8)
            chk(32'(tp), 32'(p));
    endtask
    task automatic ret();
        tr <= 1'b1;
        @(posedge clk_i);
        tr <= 1'b0;
    endtask
    task automatic send(input logic [5:0] v);
        go <= 1'b1;
        gv <= v;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rst8();
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    initial
    begin
        rst8();
        wb(1'b0, `TLIVU_OFF_STATE, 32'h0);
        chk(q, 32'h10);
        for (int i = 0; i < 8; i++)
        begin
            fire(i, xt[i], xp[i]);
            ret();
        end
        fire(8, `TLIVU_TT_HTRAP_BASE | 9'h005, 10'h0);
        ret();
        sw <= 7'h7a;
        fire(8, `TLIVU_TT_HTRAP_BASE | 9'h07a, 10'h0);
        ret();
        wb(1'b1, `TLIVU_OFF_STATE, 32'h110);
        fire(4, `TLIVU_TT_STRAND_MON, `TLIVU_PRI_MONDO);
        ret();
        chk(32'(bpe), 32'h1);
        fire(0, `TLIVU_TT_BREAKPOINT, `TLIVU_PRI_BREAKPOINT);
        ret();
        chk(32'(bpe), 32'h0);
        rst8();
        wb(1'b1, `TLIVU_OFF_STATE, 32'h0);
        fire(8, `TLIVU_TT_ILLEGAL, 10'h0);
        rst8();
        wb(1'b1, `TLIVU_OFF_STATE, 32'h20);
        repeat (3) fire(1, `TLIVU_TT_ILLEGAL, `TLIVU_PRI_ILLEGAL);
        chk(32'(te), 32'(`TLIVU_TT_WDOG_ENTRY));
        @(posedge clk_i);
        chk(32'(rec), 32'h0);
        repeat (3) fire(1, `TLIVU_TT_ILLEGAL, `TLIVU_PRI_ILLEGAL);
        cz[1] <= 1'b1;
        repeat (3) @(posedge clk_i);
        cz[1] <= 1'b0;
        chk(32'(dep), 32'h6);
        chk(32'(trap_o), 32'h0);
        rst8();
        send(6'd5);
        send(6'd63);
        send(6'd0);
        repeat (2) @(posedge clk_i);
        chk(32'(vq), 32'h1);
        chk(32'(tt), 32'h60);
        wb(1'b0, `TLIVU_OFF_RECV_LO, 32'h0);
        chk(q, 32'h21);
        wb(1'b0, `TLIVU_OFF_RECV_HI, 32'h0);
        chk(q, 32'h8000_0000);
        wb(1'b0, `TLIVU_OFF_VECTOR, 32'h0);
        chk(q, 32'd63);
        wb(1'b0, `TLIVU_OFF_VECTOR, 32'h0);
        chk(q, 32'd5);
        wb(1'b0, `TLIVU_OFF_VECTOR, 32'h0);
        chk(q, 32'd0);
        repeat (2) @(posedge clk_i);
        chk(32'(vq), 32'h0);
        wb(1'b0, 8'hfc, 32'h0);
        chk(32'(e), 32'h1);
        send(6'd40);
        send(6'd3);
        send(6'd4);
        wb(1'b1, `TLIVU_OFF_RECV_HI, 32'h0);
        wb(1'b1, `TLIVU_OFF_RECV_LO, 32'h10);
        wb(1'b0, `TLIVU_OFF_RECV_HI, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, `TLIVU_OFF_RECV_LO, 32'h0);
        chk(q, 32'h10);
        go <= 1'b1;
        gv <= 6'd2;
        @(posedge clk_i);
        go <= 1'b0;
        wb(1'b1, `TLIVU_OFF_RECV_LO, 32'h0);
        wb(1'b0, `TLIVU_OFF_RECV_LO, 32'h0);
        chk(q, 32'h4);
        rst8();
        wb(1'b1, `TLIVU_OFF_SOFTIRQ, 32'h0000_8008);
        chk(32'(tt), 32'h4f);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
